// ---- inc/dt_consts.svh ----
// offsets, field positions, reset values and timing counts of the dual timer
// assumes byte addressing on a 32-bit avalon slave, one register per word
`ifndef DT_CONSTS_SVH
`define DT_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DT_OFF_CNT8      5'h00
`define DT_OFF_OPTION    5'h04
`define DT_OFF_INTC      5'h08
`define DT_OFF_CNT16L    5'h0c
`define DT_OFF_CNT16H    5'h10
`define DT_OFF_CTL16     5'h14
`define DT_OFF_GATE      5'h18
`define DT_OFF_FLG16     5'h1c

// ----------------------------------------
// field positions
// ----------------------------------------
`define DT_OPT_EXT_BIT   5
`define DT_OPT_BYP_BIT   3
`define DT_OPT_PS_LSB    0
`define DT_INTC_EN_BIT   5
`define DT_INTC_FLG_BIT  2
`define DT_CTL_SRC_LSB   6
`define DT_CTL_PS_LSB    4
`define DT_CTL_SYNC_BIT  2
`define DT_CTL_ON_BIT    0
`define DT_GATE_EN_BIT   7
`define DT_GATE_POL_BIT  6
`define DT_GATE_VAL_BIT  2
`define DT_GATE_SS_LSB   0
`define DT_FLG_OVF_BIT   0
`define DT_FLG_EN_BIT    1

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define DT_OPTION_RST    8'hff
`define DT_CTL16_RST     8'h00
`define DT_GATE_RST      8'h00
`define DT_PHASE_Q2      2'h1
`define DT_PHASE_Q4      2'h3

`endif

// ---- inc/dt_pkg.sv ----
// types shared by the dual timer files
// assumes nothing beyond a systemverilog compiler
package dt_pkg;

    // ----------------------------------------
    // sixteen-bit clock source selection
    // ----------------------------------------
    typedef enum logic [1:0] {
        dt_src_instr = 2'b00,
        dt_src_sys   = 2'b01,
        dt_src_ext   = 2'b10,
        dt_src_rsvd  = 2'b11
    } dt_clk_src_t;

endpackage

// ---- design/dt_pin_sync.sv ----
// two-flop synchroniser for one pin, with a rising-edge pulse
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
module dt_pin_sync (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic pin,
    output logic      level,
    output logic      rise
);
    import dt_pkg::*;

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ----------------------------------------
    // synchroniser; the edge is taken after the second flop only
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign level = s2_q;
    assign rise  = s2_q & ~s3_q;
endmodule

// ---- design/dt_prescale.sv ----
// power-of-two prescaler: passes one tick out of 2**div_log2
// assumes tick and clr come from logic on clk
`timescale 1ns/1ps
module dt_prescale (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       clr,
    input  wire logic       tick,
    input  wire logic [3:0] div_log2,
    output logic            tick_out,
    output logic [7:0]      cnt
);
    import dt_pkg::*;

    logic [7:0] mask;

    // ----------------------------------------
    // divider
    // ----------------------------------------
    assign mask     = 8'((9'h001 << div_log2) - 9'h001);
    assign tick_out = tick & ~clr & ((cnt & mask) == mask);

    // a clear beats a tick, so a count write always restarts the ratio
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 8'h00;
        end else if (clr) begin
            cnt <= 8'h00;
        end else if (tick) begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

// ---- design/dt_timer_top.sv ----
// dual timer: 8-bit timer with its own prescaler, 16-bit timer with gate
// assumes an avalon-mm master on clk and pins asynchronous to clk
// Function
// [RULE_01] 8-bit count goes through the prescaler only when bypass is clear
// [RULE_02] eight ratios 1:2 to 1:256 chosen by a three-bit select
// [RULE_03] bypass set makes the 8-bit timer count 1:1
// [RULE_04] prescaler hidden from software; writing the 8-bit count clears it
// [RULE_05] roll from ff to 00 sets the 8-bit overflow flag always
// [RULE_06] only a software write clears the 8-bit overflow flag
// [RULE_07] 8-bit interrupt request only when its enable bit is set
// [RULE_08] external 8-bit counting sampled on phases q2 and q4
// [RULE_09] sleep freezes the 8-bit count; it cannot wake
// [RULE_10] 16-bit clock divided by 1, 2, 4 or 8 from a two-bit field
// [RULE_11] 16-bit prescaler hidden; any count byte write clears it
// [RULE_12] sync disable lets the 16-bit timer count straight from pin edges
// [RULE_13] async external mode keeps counting in sleep and may wake
// [RULE_14] mode switches may lose or add one increment
// [RULE_15] count byte reads are valid while counting asynchronously
// [RULE_16] software should stop the 16-bit timer before writing it
// [RULE_17] gate control only when gate enable is set, else free running
// [RULE_18] gate polarity picks the gate level that lets the timer count
// [RULE_19] active gate: increment on each rising edge of the source
// [RULE_20] inactive gate: the 16-bit count holds
// [RULE_21] two-bit gate source select, 0 is the gate pin, polarity applies
// [RULE_22] 16-bit count as two bytes with its own overflow flag
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "dt_consts.svh"
module dt_timer_top (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        sleep,
    input  wire logic        eight_bit_ext_clock_pin,
    input  wire logic        sixteen_bit_ext_clock_pin,
    input  wire logic        gate_pin,
    input  wire logic [2:0]  gate_alt_src,
    output logic             eight_bit_irq,
    output logic             sixteen_bit_irq,
    output logic             wake_req
);
    import dt_pkg::*;

    function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
        hit = (addr == off);
    endfunction

    logic        wait_q;
    logic [31:0] rdata_d;
    logic        wr_en;
    logic [7:0]  wdat;
    logic        wr_cnt8;
    logic        wr_opt;
    logic        wr_intc;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_ctl;
    logic        wr_gate;
    logic        wr_flg;
    logic [1:0]  phase_q;
    logic        run;
    logic        q2;
    logic        q4;
    logic [2:0]  pin_bus;
    logic [2:0]  pin_lvl;
    logic [2:0]  pin_rise;
    logic [7:0]  opt_q;
    logic        en8_q;
    logic        flag8_q;
    logic [7:0]  cnt8_q;
    logic        ext8;
    logic        bypass;
    logic [3:0]  exp8;
    logic        tick8;
    logic        p8;
    logic [7:0]  pre8_cnt;
    logic        pend8_q;
    logic        inc8;
    logic        ovf8;
    logic [7:0]  ctl_q;
    logic [7:0]  gate_q;
    logic        en16_q;
    logic        flag16_q;
    logic [15:0] cnt16_q;
    dt_clk_src_t src16;
    logic        sync_dis;
    logic        on16;
    logic        pend16_q;
    logic        src_tick;
    logic        gate_lvl;
    logic        gate_ok;
    logic        tick16;
    logic        p16;
    logic [7:0]  pre16_cnt;
    logic        ovf16;

    // ----------------------------------------
    // avalon slave: one wait cycle, then a one-cycle answer
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(wait_q & (avs_read | avs_write));
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (wait_q & avs_read) begin
            avs_readdata <= rdata_d;
        end
    end

    assign avs_waitrequest = wait_q;
    assign wr_en   = avs_write & ~wait_q & avs_byteenable[0];
    assign wdat    = avs_writedata[7:0];
    assign wr_cnt8 = wr_en & hit(avs_address, `DT_OFF_CNT8);
    assign wr_opt  = wr_en & hit(avs_address, `DT_OFF_OPTION);
    assign wr_intc = wr_en & hit(avs_address, `DT_OFF_INTC);
    assign wr_lo   = wr_en & hit(avs_address, `DT_OFF_CNT16L);
    assign wr_hi   = wr_en & hit(avs_address, `DT_OFF_CNT16H);
    assign wr_ctl  = wr_en & hit(avs_address, `DT_OFF_CTL16);
    assign wr_gate = wr_en & hit(avs_address, `DT_OFF_GATE);
    assign wr_flg  = wr_en & hit(avs_address, `DT_OFF_FLG16);

    // single-clock capture keeps count reads whole even in async mode
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit(avs_address, `DT_OFF_CNT8)) begin
            rdata_d[7:0] = cnt8_q;
        end else if (hit(avs_address, `DT_OFF_OPTION)) begin
            rdata_d[7:0] = opt_q;
        end else if (hit(avs_address, `DT_OFF_INTC)) begin
            rdata_d[`DT_INTC_EN_BIT]  = en8_q;
            rdata_d[`DT_INTC_FLG_BIT] = flag8_q;
        end else if (hit(avs_address, `DT_OFF_CNT16L)) begin
            rdata_d[7:0] = cnt16_q[7:0]; // [RULE_15]
        end else if (hit(avs_address, `DT_OFF_CNT16H)) begin
            rdata_d[7:0] = cnt16_q[15:8]; // [RULE_15]
        end else if (hit(avs_address, `DT_OFF_CTL16)) begin
            rdata_d[7:0] = ctl_q;
        end else if (hit(avs_address, `DT_OFF_GATE)) begin
            rdata_d[7:0] = gate_q;
            rdata_d[`DT_GATE_VAL_BIT] = gate_ok;
        end else if (hit(avs_address, `DT_OFF_FLG16)) begin
            rdata_d[`DT_FLG_OVF_BIT] = flag16_q;
            rdata_d[`DT_FLG_EN_BIT]  = en16_q;
        end
    end

    // ----------------------------------------
    // instruction phases; they stop in sleep like the core clock
    // ----------------------------------------
    assign run = ~sleep;
    assign q2  = run & (phase_q == `DT_PHASE_Q2);
    assign q4  = run & (phase_q == `DT_PHASE_Q4);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= 2'h0;
        end else if (run) begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    assign pin_bus = {gate_pin, sixteen_bit_ext_clock_pin, eight_bit_ext_clock_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            dt_pin_sync u_sync (
                .clk     (clk),
                .sys_rst (sys_rst),
                .pin     (pin_bus[gi]),
                .level   (pin_lvl[gi]),
                .rise    (pin_rise[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // 8-bit timer
    // ----------------------------------------
    assign ext8   = opt_q[`DT_OPT_EXT_BIT];
    assign bypass = opt_q[`DT_OPT_BYP_BIT]; // [RULE_03]
    assign exp8   = bypass ? 4'h0 : ({1'b0, opt_q[`DT_OPT_PS_LSB +: 3]} + 4'h1); // [RULE_01]
    assign tick8  = run & (ext8 ? pin_rise[0] : q4); // [RULE_09]

    dt_prescale u_pre8 (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .clr      (wr_cnt8), // [RULE_04]
        .tick     (tick8),
        .div_log2 (exp8), // [RULE_02]
        .tick_out (p8),
        .cnt      (pre8_cnt)
    );

    // counter mode: prescaler output is held and taken on q2 or q4
    assign inc8 = ext8 ? (pend8_q & (q2 | q4)) : p8; // [RULE_08]
    assign ovf8 = inc8 & (cnt8_q == 8'hff) & ~wr_cnt8;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend8_q <= 1'b0;
        end else if (p8 & ext8) begin
            pend8_q <= 1'b1;
        end else if (inc8 | ~ext8) begin
            pend8_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt8_q <= 8'h00;
        end else if (wr_cnt8) begin
            cnt8_q <= wdat;
        end else if (inc8) begin
            cnt8_q <= cnt8_q + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            opt_q <= `DT_OPTION_RST;
            en8_q <= 1'b0;
        end else begin
            if (wr_opt) begin
                opt_q <= wdat;
            end
            if (wr_intc) begin
                en8_q <= wdat[`DT_INTC_EN_BIT];
            end
        end
    end

    // a roll in the same cycle as a clearing write keeps the flag set
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag8_q <= 1'b0;
        end else if (ovf8) begin
            flag8_q <= 1'b1; // [RULE_05]
        end else if (wr_intc) begin
            flag8_q <= wdat[`DT_INTC_FLG_BIT]; // [RULE_06]
        end
    end

    // ----------------------------------------
    // 16-bit timer
    // ----------------------------------------
    assign src16    = dt_clk_src_t'(ctl_q[`DT_CTL_SRC_LSB +: 2]);
    assign sync_dis = ctl_q[`DT_CTL_SYNC_BIT];
    assign on16     = ctl_q[`DT_CTL_ON_BIT];

    // pending edge is dropped when sync is disabled, so a switch may
    // lose or gain one count
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend16_q <= 1'b0;
        end else if (pin_rise[1] & ~sync_dis) begin
            pend16_q <= 1'b1;
        end else if (q4 | sync_dis) begin
            pend16_q <= 1'b0; // [RULE_14]
        end
    end

    always_comb begin
        case (src16)
            dt_src_instr: src_tick = q4;
            dt_src_sys:   src_tick = run;
            dt_src_ext: begin
                // async path ignores run, so it keeps going in sleep
                src_tick = sync_dis ? pin_rise[1] : (pend16_q & q4); // [RULE_12]
            end
            default:      src_tick = 1'b0;
        endcase
    end

    assign gate_lvl = (gate_q[`DT_GATE_SS_LSB +: 2] == 2'h0) ? pin_lvl[2] :
                      gate_alt_src[gate_q[`DT_GATE_SS_LSB +: 2] - 2'h1]; // [RULE_21]
    assign gate_ok  = ~gate_q[`DT_GATE_EN_BIT] |
                      (gate_lvl == gate_q[`DT_GATE_POL_BIT]); // [RULE_17]
    assign tick16   = on16 & gate_ok & src_tick; // [RULE_19]

    dt_prescale u_pre16 (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .clr      (wr_lo | wr_hi), // [RULE_11]
        .tick     (tick16),
        .div_log2 ({2'b00, ctl_q[`DT_CTL_PS_LSB +: 2]}), // [RULE_10]
        .tick_out (p16),
        .cnt      (pre16_cnt)
    );

    assign ovf16 = p16 & (cnt16_q == 16'hffff) & ~(wr_lo | wr_hi);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt16_q <= 16'h0000;
        end else if (wr_lo) begin
            cnt16_q[7:0] <= wdat;
        end else if (wr_hi) begin
            cnt16_q[15:8] <= wdat;
        end else if (p16) begin // [RULE_20]
            cnt16_q <= cnt16_q + 16'h0001; // [RULE_22]
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_q  <= `DT_CTL16_RST;
            gate_q <= `DT_GATE_RST;
            en16_q <= 1'b0;
        end else begin
            if (wr_ctl) begin
                ctl_q <= wdat;
            end
            if (wr_gate) begin
                gate_q <= wdat; // [RULE_18]
            end
            if (wr_flg) begin
                en16_q <= wdat[`DT_FLG_EN_BIT];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag16_q <= 1'b0;
        end else if (ovf16) begin
            flag16_q <= 1'b1; // [RULE_22]
        end else if (wr_flg) begin
            flag16_q <= wdat[`DT_FLG_OVF_BIT];
        end
    end

    // ----------------------------------------
    // requests; only the 16-bit timer can wake, the 8-bit one is frozen
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            eight_bit_irq   <= 1'b0;
            sixteen_bit_irq <= 1'b0;
            wake_req        <= 1'b0;
        end else begin
            eight_bit_irq   <= flag8_q & en8_q; // [RULE_07]
            sixteen_bit_irq <= flag16_q & en16_q;
            wake_req        <= sleep & flag16_q & en16_q; // [RULE_13]
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_bypass_rate: assert property ( // [RULE_03]
        @(posedge clk) disable iff (sys_rst)
        (bypass && !ext8 && q4 && !wr_cnt8) |-> inc8
    ) else $error("bypassed 8-bit timer missed an instruction cycle");

    chk_ratio_min: assert property ( // [RULE_02]
        @(posedge clk) disable iff (sys_rst)
        (!bypass && !ext8 && q4 && !pre8_cnt[0] && !wr_cnt8) |-> !inc8
    ) else $error("prescaled 8-bit timer counted faster than 1:2");

    chk_pre8_clear: assert property ( // [RULE_04]
        @(posedge clk) disable iff (sys_rst)
        wr_cnt8 |=> (pre8_cnt == 8'h00) && (cnt8_q == $past(wdat))
    ) else $error("8-bit count write did not clear the prescaler");

    chk_ovf8_set: assert property ( // [RULE_05]
        @(posedge clk) disable iff (sys_rst)
        (inc8 && cnt8_q == 8'hff && !wr_cnt8) |=> (flag8_q && cnt8_q == 8'h00)
    ) else $error("8-bit roll did not set the overflow flag");

    chk_ovf8_sticky: assert property ( // [RULE_06]
        @(posedge clk) disable iff (sys_rst)
        (flag8_q && !wr_intc) |=> flag8_q
    ) else $error("8-bit overflow flag cleared without a write");

    chk_irq8_enable: assert property ( // [RULE_07]
        @(posedge clk) disable iff (sys_rst)
        eight_bit_irq |-> ($past(en8_q) && $past(flag8_q))
    ) else $error("8-bit request raised while disabled");

    chk_sleep_freeze: assert property ( // [RULE_09]
        @(posedge clk) disable iff (sys_rst)
        (sleep && !wr_cnt8) |=> $stable(cnt8_q)
    ) else $error("8-bit count moved during sleep");

    chk_pre16_clear: assert property ( // [RULE_11]
        @(posedge clk) disable iff (sys_rst)
        (wr_lo || wr_hi) |=> (pre16_cnt == 8'h00)
    ) else $error("16-bit byte write did not clear the prescaler");

    chk_async_sleep: assert property ( // [RULE_13]
        @(posedge clk) disable iff (sys_rst)
        (sleep && src16 == dt_src_ext && sync_dis && on16 && !gate_q[`DT_GATE_EN_BIT]
         && ctl_q[`DT_CTL_PS_LSB +: 2] == 2'h0 && pin_rise[1] && !wr_lo && !wr_hi)
        |=> (cnt16_q == $past(cnt16_q) + 16'h0001)
    ) else $error("async 16-bit timer did not count in sleep");

    chk_gate_hold: assert property ( // [RULE_20]
        @(posedge clk) disable iff (sys_rst)
        (gate_q[`DT_GATE_EN_BIT] && gate_lvl != gate_q[`DT_GATE_POL_BIT]
         && !wr_lo && !wr_hi) |=> $stable(cnt16_q)
    ) else $error("16-bit count moved with the gate inactive");

    chk_ovf16_set: assert property ( // [RULE_22]
        @(posedge clk) disable iff (sys_rst)
        (p16 && cnt16_q == 16'hffff && !wr_lo && !wr_hi) |=> (flag16_q && cnt16_q == 16'h0000)
    ) else $error("16-bit roll did not set its overflow flag");
endmodule

// ---- tb/dt_pin_model.sv ----
// partner model: external counting pins driven from outside the timer
// assumes the block synchronises both pins to its own clock
`timescale 1ns/1ps
module dt_pin_model (
    input  logic clk,
    output logic pin8,
    output logic pin16
);
    // ----------------------------------------
    // pin activity
    // ----------------------------------------
    initial begin
        pin8 = 1'b0;
        pin16 = 1'b0;
    end
    // half period of 5 clocks: each rise is taken well before the next one,
    // even when a pending 8-bit edge waits for q2 or q4
    task automatic pulse(input logic sel, input int n);
        for (int i = 0; i < 2 * n; i++) begin
            repeat (5) @(posedge clk);
            if (sel)
                pin16 <= ~pin16;
            else
                pin8 <= ~pin8;
        end
    endtask
endmodule

// ---- tb/tb_dual_timer_prescale_gate.sv ----
// bench for the dual timer: avalon driver, queued read checks, pin partner
// assumes the timer top module, its constants header and the pin model
`timescale 1ns/1ps
`include "dt_consts.svh"
module tb_dual_timer_prescale_gate;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        sleep = 1'b1;
    logic        eight_bit_ext_clock_pin;
    logic        sixteen_bit_ext_clock_pin;
    logic        gate_pin = 1'b0;
    logic [2:0]  gate_alt_src = 3'h0;
    logic        eight_bit_irq;
    logic        sixteen_bit_irq;
    logic        wake_req;
    logic [7:0]  exp_q[$];
    logic [7:0]  st;
    logic [15:0] s16;
    int          per;
    int          mismatches = 0;
    int          check_count = 0;

    always #2.5 clk = ~clk;

    dt_timer_top dut_u (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .sleep,
        .eight_bit_ext_clock_pin, .sixteen_bit_ext_clock_pin, .gate_pin,
        .gate_alt_src, .eight_bit_irq, .sixteen_bit_irq, .wake_req);
    dt_pin_model pm_u (.clk(clk), .pin8(eight_bit_ext_clock_pin),
        .pin16(sixteen_bit_ext_clock_pin));

    // ----------------------------------------
    // reporting and bus tasks
    // ----------------------------------------
    task automatic fail(input string m);
        mismatches++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic g, input logic e, input string m);
        check_count++;
        if (g !== e)
            fail(m);
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= {24'h0, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        if (i == 20) begin
            fail("bus answer timed out");
            close_out();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h0);
    endtask
    // phase counter is frozen in sleep, so n awake edges give an exact count
    task automatic awake(input int n);
        @(posedge clk);
        sleep <= 1'b0;
        repeat (n) @(posedge clk);
        sleep <= 1'b1;
    endtask
    task automatic gwin(input int n, input logic lv, input logic [1:0] ss);
        @(posedge clk);
        if (ss == 2'h0)
            gate_pin <= lv;
        else
            gate_alt_src[ss - 2'h1] <= lv;
        repeat (n) @(posedge clk);
        gate_pin <= ~lv;
        gate_alt_src <= {3{~lv}};
        repeat (6) @(posedge clk);
    endtask

    // ----------------------------------------
    // read checker: oldest note against each answer
    // ----------------------------------------
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            check_count++;
            if (exp_q.size() == 0)
                fail("read with no expectation");
            else if (avs_readdata !== {24'h0, exp_q.pop_front()})
                fail("read data differs");
        end
    end

    initial begin
        #200us;
        fail("run timed out");
        close_out();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(91));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`DT_OFF_OPTION, `DT_OPTION_RST);
        rd(`DT_OFF_GATE, 8'h04);
        rd(`DT_OFF_INTC, 8'h00);
        for (int i = 0; i < 9; i++) begin
            per = (i == 8) ? 8 : 4 << (i + 1);
            st = (i == 2) ? 8'hff : 8'($urandom);
            wr(`DT_OFF_OPTION, (i == 8) ? 8'h08 : 8'(i));
            awake(per / 2);
            wr(`DT_OFF_CNT8, st);
            rd(`DT_OFF_CNT8, st);
            awake(per / 2);
            rd(`DT_OFF_CNT8, st + ((i == 8) ? 8'h1 : 8'h0));
            awake(per / 2);
            rd(`DT_OFF_CNT8, st + ((i == 8) ? 8'h2 : 8'h1));
        end
        rd(`DT_OFF_INTC, 8'h04);
        chk(eight_bit_irq, 1'b0, "irq raised while disabled");
        wr(`DT_OFF_INTC, 8'h24);
        repeat (3) @(negedge clk);
        chk(eight_bit_irq, 1'b1, "irq missing when enabled");
        wr(`DT_OFF_INTC, 8'h20);
        repeat (3) @(negedge clk);
        chk(eight_bit_irq, 1'b0, "irq stays after clear");
        @(posedge clk);
        sleep <= 1'b0;
        wr(`DT_OFF_OPTION, 8'h28);
        wr(`DT_OFF_CNT8, 8'h00);
        pm_u.pulse(1'b0, 5);
        repeat (10) @(posedge clk);
        rd(`DT_OFF_CNT8, 8'h05);
        for (int ps = 0; ps < 4; ps++) begin
            s16 = (ps == 3) ? 16'hfffc : 16'($urandom);
            @(posedge clk);
            gate_pin <= ~ps[0];
            gate_alt_src <= {3{~ps[0]}};
            wr(`DT_OFF_GATE, {1'b1, ps[0], 4'h0, 2'(ps)});
            wr(`DT_OFF_CTL16, {2'b01, 2'(ps), 4'h1});
            rd(`DT_OFF_GATE, {1'b1, ps[0], 4'h0, 2'(ps)});
            wr(`DT_OFF_CNT16L, s16[7:0]);
            wr(`DT_OFF_CNT16H, s16[15:8]);
            gwin(8 << ps, ps[0], 2'(ps));
            s16 = s16 + 16'h8;
            rd(`DT_OFF_CNT16L, s16[7:0]);
            rd(`DT_OFF_CNT16H, s16[15:8]);
        end
        rd(`DT_OFF_FLG16, 8'h01);
        wr(`DT_OFF_FLG16, 8'h03);
        sleep <= 1'b1;
        repeat (3) @(negedge clk);
        chk(sixteen_bit_irq, 1'b1, "16-bit irq missing");
        chk(wake_req, 1'b1, "wake missing in sleep");
        wr(`DT_OFF_FLG16, 8'h02);
        repeat (3) @(negedge clk);
        chk(wake_req, 1'b0, "wake stays after clear");
        @(posedge clk);
        gate_pin <= 1'b0;
        wr(`DT_OFF_GATE, 8'h40);
        wr(`DT_OFF_CTL16, 8'h85);
        wr(`DT_OFF_CNT16L, 8'h00);
        wr(`DT_OFF_CNT16H, 8'h00);
        pm_u.pulse(1'b1, 6);
        repeat (10) @(posedge clk);
        rd(`DT_OFF_CNT16L, 8'h06);
        // synchronised external counting needs the phases, so wake up first
        sleep <= 1'b0;
        wr(`DT_OFF_CTL16, 8'h81);
        wr(`DT_OFF_CNT16L, 8'h00);
        wr(`DT_OFF_CNT16H, 8'h00);
        pm_u.pulse(1'b1, 4);
        repeat (10) @(posedge clk);
        rd(`DT_OFF_CNT16L, 8'h04);
        // a write without byte lane 0 is ignored
        avs_byteenable <= 4'he;
        wr(`DT_OFF_CNT16L, 8'h55);
        avs_byteenable <= 4'hf;
        rd(`DT_OFF_CNT16L, 8'h04);
        close_out();
    end
endmodule
